//--- hw/skew_fanout_pkg.sv
`default_nettype none
// Shared constants for the programmable skew clock fanout block.
package skew_fanout_pkg;

  // Number of independent output sections, each with two drivers.
  localparam int PAIRS = 4;

  // Three-level select encodings; code 3 stands for an open (floating) pin.
  typedef enum logic [1:0] {
    LVL_LOW  = 2'b00,
    LVL_MID  = 2'b01,
    LVL_HIGH = 2'b10,
    LVL_OPEN = 2'b11
  } level_e;

  // Output behaviours a section can take.
  typedef enum logic [1:0] {
    FN_SKEW = 2'b00,
    FN_DIV2 = 2'b01,
    FN_DIV4 = 2'b10,
    FN_INV  = 2'b11
  } func_e;

  // Register map, byte addresses of aligned 32-bit words.
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_SELECT = 12'h000;
  localparam logic [11:0] ADDR_CONTROL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // Select register: four bits per section, lower select in the low half.
  localparam int SEL_W = 16;
  localparam int SEL_FIELD_W = 4;
  localparam int SEL_LOWER_LSB = 0;
  localparam int SEL_UPPER_LSB = 2;
  // Every select reads as the middle level (code 1), not the open code, after reset.
  localparam logic [15:0] SELECT_RESET = 16'h5555;

  // Control register: range select and test select.
  localparam int CTRL_W = 4;
  localparam int CTRL_RANGE_LSB = 0;
  localparam int CTRL_TEST_LSB = 2;
  // Range middle, test low (normal loop operation) after reset.
  localparam logic [3:0] CONTROL_RESET = 4'h1;

  // Status register fields.
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_BYPASS_BIT = 1;
  localparam int STAT_ERR_LSB = 8;
  localparam int ERR_W = 8;

  // Ticks per nominal period for each range: 44, 26 and 16.
  localparam int PHASE_W = 6;
  localparam logic [5:0] N_LOW = 6'h2C;
  localparam logic [5:0] N_MID = 6'h1A;
  localparam logic [5:0] N_HIGH = 6'h10;

  // Skew codes and the bypass delay line.
  localparam logic [3:0] ZERO_IDX = 4'h4;
  localparam logic [3:0] LAST_IDX = 4'h8;
  localparam logic [3:0] DLY_CENTER = 4'h6;
  localparam int DLY_DEPTH = 13;

  // Lock detection: tolerance in ticks and aligned comparisons needed.
  localparam logic [7:0] LOCK_TOL = 8'h01;
  localparam logic [4:0] LOCK_COUNT = 5'h10;
  localparam logic [7:0] ERR_MAX = 8'hFF;

endpackage
`default_nettype wire

//--- hw/programmable_skew_clock_fanout.sv
`timescale 1ns/1ps
`default_nettype none
module programmable_skew_clock_fanout
  import skew_fanout_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic refClk,
  input wire logic loopReturnInput,
  output logic [PAIRS-1:0] pairOutputA,
  output logic [PAIRS-1:0] pairOutputB
);

  // Maps the open code onto the middle level, as an open pin would float.
  function automatic logic [1:0] levelValue(input logic [1:0] code);
    levelValue = (code == LVL_OPEN) ? LVL_MID : code;
  endfunction

  logic [SEL_W-1:0] selectReg_r; // Section select levels.
  logic [CTRL_W-1:0] controlReg_r; // Range and test select levels.
  logic [31:0] prdata_r; // Read data captured in the setup cycle.
  logic [31:0] readMux; // Read data for the addressed register.
  logic mapped; // The address hits one of the registers.
  logic refSync1_r; // First stage of the input clock synchroniser.
  logic refSync_r; // Synchronised input clock level.
  logic refPrev_r; // Input clock level one tick earlier.
  logic fbSync1_r; // First stage of the loop-return synchroniser.
  logic fbSync_r; // Synchronised loop-return level.
  logic fbPrev_r; // Loop-return level one tick earlier.
  logic refRise; // Rising edge seen on the input clock.
  logic fbRise; // Rising edge seen on the loop return.
  logic [PHASE_W-1:0] nLen; // Ticks per nominal period.
  logic bypass; // Loop is bypassed by the test select.
  logic [PHASE_W-1:0] sub_r; // Tick position inside the nominal period.
  logic [1:0] cyc_r; // Nominal period count for the dividers.
  logic [PHASE_W:0] subStep; // Sub position after this tick's step.
  logic upFlag_r; // Input edge came first, waiting for return.
  logic dnFlag_r; // Return edge came first, waiting for input.
  logic [ERR_W-1:0] errCnt_r; // Ticks between the two compared edges.
  logic [ERR_W-1:0] lastErr_r; // Error of the last finished comparison.
  logic [4:0] lockCnt_r; // Run of comparisons inside tolerance.
  logic locked; // Loop is considered locked.
  logic nudgeAdvance; // Outputs are late: skip one tick.
  logic nudgeHold; // Outputs are early: stall one tick.
  logic resolved; // A comparison finishes this tick.
  logic [ERR_W-1:0] resolvedErr; // Error of the finishing comparison.
  logic [DLY_DEPTH-1:0] refDly_r; // Input clock history for bypass taps.
  logic dlyRise; // Rising edge at the centre tap of the history.
  logic [PAIRS-1:0] outNxt; // Next level of each section's drivers.

  // The slave never waits; a request is answered in its first access cycle.
  assign pready = 1'b1;
  assign mapped = (paddr == ADDR_SELECT) || (paddr == ADDR_CONTROL) ||
                  (paddr == ADDR_STATUS);
  // Unmapped addresses report an error in the access phase.
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;

  // Selects the register read back; unused bits read as zero.
  always_comb begin
    readMux = 32'h0000_0000;
    case (paddr)
      ADDR_SELECT: begin
        readMux[SEL_W-1:0] = selectReg_r;
      end
      ADDR_CONTROL: begin
        readMux[CTRL_W-1:0] = controlReg_r;
      end
      ADDR_STATUS: begin
        readMux[STAT_LOCK_BIT] = locked;
        readMux[STAT_BYPASS_BIT] = bypass;
        readMux[STAT_ERR_LSB +: ERR_W] = lastErr_r;
      end
      default: begin
        readMux = 32'h0000_0000;
      end
    endcase
  end

  // Captures read data in the setup cycle so it stands through access.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= readMux;
    end
  end

  // Software writes take effect in the access cycle; status is read-only.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      selectReg_r <= SELECT_RESET;
      controlReg_r <= CONTROL_RESET;
    end else if (psel && penable && pwrite) begin
      if (paddr == ADDR_SELECT) begin
        selectReg_r <= pwdata[SEL_W-1:0];
      end
      if (paddr == ADDR_CONTROL) begin
        controlReg_r <= pwdata[CTRL_W-1:0];
      end
    end
  end

  // Brings both clock pins into the tick domain through two flip-flops.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      refSync1_r <= 1'b0;
      refSync_r <= 1'b0;
      refPrev_r <= 1'b0;
      fbSync1_r <= 1'b0;
      fbSync_r <= 1'b0;
      fbPrev_r <= 1'b0;
    end else begin
      refSync1_r <= refClk;
      refSync_r <= refSync1_r;
      refPrev_r <= refSync_r;
      fbSync1_r <= loopReturnInput;
      fbSync_r <= fbSync1_r;
      fbPrev_r <= fbSync_r;
    end
  end

  assign refRise = refSync_r && !refPrev_r;
  assign fbRise = fbSync_r && !fbPrev_r;

  // Range select picks how many ticks make one nominal period.
  always_comb begin
    case (levelValue(controlReg_r[CTRL_RANGE_LSB +: 2]))
      LVL_LOW: nLen = N_LOW;
      LVL_HIGH: nLen = N_HIGH;
      default: nLen = N_MID;
    endcase
  end

  // A low test select keeps the loop; middle or high bypasses it.
  assign bypass =
    levelValue(controlReg_r[CTRL_TEST_LSB +: 2]) != LVL_LOW;

  // Edge comparison: whichever edge leads decides the correction.
  // Any output may be fed back, so divided or inverted feedback moves
  // every other output accordingly without further logic.
  assign nudgeAdvance = !bypass && fbRise && !refRise && upFlag_r;
  assign nudgeHold = !bypass && refRise && !fbRise && dnFlag_r;
  assign resolved = !bypass &&
    ((refRise && fbRise) || nudgeAdvance || nudgeHold);
  assign resolvedErr = (refRise && fbRise) ? 8'h00 : errCnt_r;

  // Tracks which edge came first and how far apart the pair was.
  always_ff @(posedge clock) begin
    if (!nrst || bypass) begin
      upFlag_r <= 1'b0;
      dnFlag_r <= 1'b0;
      errCnt_r <= 8'h00;
    end else if (refRise && fbRise) begin
      // Edges coincide, so the pair is aligned.
      upFlag_r <= 1'b0;
      dnFlag_r <= 1'b0;
      errCnt_r <= 8'h00;
    end else if (refRise) begin
      // The input edge either closes a return-led pair or opens one.
      upFlag_r <= !dnFlag_r;
      dnFlag_r <= 1'b0;
      errCnt_r <= 8'h00;
    end else if (fbRise) begin
      // The return edge either closes an input-led pair or opens one.
      dnFlag_r <= !upFlag_r;
      upFlag_r <= 1'b0;
      errCnt_r <= 8'h00;
    end else if ((upFlag_r || dnFlag_r) && errCnt_r != ERR_MAX) begin
      errCnt_r <= errCnt_r + 8'h01;
    end
  end

  // Keeps the last error and the run of aligned comparisons.
  always_ff @(posedge clock) begin
    if (!nrst || bypass) begin
      lastErr_r <= 8'h00;
      lockCnt_r <= 5'h00;
    end else if (resolved) begin
      lastErr_r <= resolvedErr;
      if (resolvedErr > LOCK_TOL) begin
        lockCnt_r <= 5'h00;
      end else if (lockCnt_r != LOCK_COUNT) begin
        lockCnt_r <= lockCnt_r + 5'h01;
      end
    end else if (errCnt_r == ERR_MAX) begin
      // A pair left open for 255 ticks with no edge on either pin drops the lock.
      lockCnt_r <= 5'h00;
    end
  end

  assign locked = lockCnt_r == LOCK_COUNT;

  // Step for this tick: one normally, two to catch up, none to wait.
  always_comb begin
    if (nudgeHold) begin
      subStep = {1'b0, sub_r};
    end else if (nudgeAdvance) begin
      subStep = {1'b0, sub_r} + 7'h02;
    end else begin
      subStep = {1'b0, sub_r} + 7'h01;
    end
  end

  // Tick counter standing in for the oscillator and time unit generator.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sub_r <= 6'h00;
      cyc_r <= 2'h0;
    end else if (bypass) begin
      // The input clock itself paces the dividers in bypass.
      sub_r <= 6'h00;
      if (dlyRise) begin
        cyc_r <= cyc_r + 2'h1;
      end
    end else if (subStep >= {1'b0, nLen}) begin
      sub_r <= PHASE_W'(subStep - {1'b0, nLen});
      cyc_r <= cyc_r + 2'h1;
    end else begin
      sub_r <= subStep[PHASE_W-1:0];
    end
  end

  // History of the input clock; the centre tap is the zero-skew point.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      refDly_r <= '0;
    end else begin
      refDly_r <= {refDly_r[DLY_DEPTH-2:0], refSync_r};
    end
  end

  assign dlyRise = refDly_r[DLY_CENTER] && !refDly_r[DLY_CENTER + 4'h1];

  // One section per pair, all running side by side; pairs three and four also decode divide codes, and pair four an invert code.
  for (genvar p = 0; p < PAIRS; p++) begin : g_pair
    logic [1:0] upper; // Upper select level of this section.
    logic [1:0] lower; // Lower select level of this section.
    logic [3:0] idx; // Select code, upper most significant.
    logic signed [4:0] skew; // Offset in ticks.
    logic [1:0] func; // Behaviour of this section.
    logic signed [7:0] shifted; // Sub position moved by the skew.
    logic [PHASE_W-1:0] phase; // Wrapped position for this section.
    logic [1:0] cycle; // Period count for this section.
    logic [3:0] tap; // History tap used in bypass.
    logic aligned; // Non-inverted level with this skew.

    assign upper = levelValue(selectReg_r[p*SEL_FIELD_W+SEL_UPPER_LSB +: 2]);
    assign lower = levelValue(selectReg_r[p*SEL_FIELD_W+SEL_LOWER_LSB +: 2]);
    assign idx = 4'({2'b00, upper} * 4'h3) + {2'b00, lower};

    // Decodes the nine select codes into a function and a skew.
    always_comb begin
      func = FN_SKEW;
      skew = 5'sh00;
      if (p < 2) begin
        skew = $signed({1'b0, idx}) - $signed({1'b0, ZERO_IDX});
      end else if (idx == 4'h0) begin
        func = FN_DIV2;
      end else if (idx == LAST_IDX) begin
        func = (p == 2) ? FN_DIV4 : FN_INV;
      end else begin
        skew = ($signed({1'b0, idx}) - $signed({1'b0, ZERO_IDX})) <<< 1;
      end
    end

    // Places the edge the skew's tick count from the aligned edge;
    // feedback skew shifts all outputs by the loop's correction.
    always_comb begin
      shifted = $signed({2'b00, sub_r}) - 8'(skew);
      cycle = cyc_r;
      phase = sub_r;
      if (shifted < 8'sh00) begin
        phase = PHASE_W'(shifted + $signed({2'b00, nLen}));
        cycle = cyc_r - 2'h1;
      end else if (shifted >= $signed({2'b00, nLen})) begin
        phase = PHASE_W'(shifted - $signed({2'b00, nLen}));
        cycle = cyc_r + 2'h1;
      end else begin
        phase = shifted[PHASE_W-1:0];
      end
    end

    assign tap = 4'(DLY_CENTER + 4'(skew));
    // Loop mode: high for the first half of each nominal period.
    // Bypass mode: the input clock delayed by the skew.
    assign aligned = bypass ? refDly_r[tap]
                            : (phase < (nLen >> 1));

    // Picks the level of this section's drivers.
    always_comb begin
      case (func)
        // Divide by two falls at periods one and three.
        FN_DIV2: outNxt[p] = !cycle[0];
        // Divide by four is high in periods one and two, falling with it.
        FN_DIV4: outNxt[p] = (cycle == 2'h1) || (cycle == 2'h2);
        // Half a period away from the zero-skew outputs.
        FN_INV: outNxt[p] = !aligned;
        default: outNxt[p] = aligned;
      endcase
    end
  end

  // Both drivers of a section carry the same registered level.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pairOutputA <= '0;
      pairOutputB <= '0;
    end else begin
      pairOutputA <= outNxt;
      pairOutputB <= outNxt;
    end
  end

endmodule // programmable_skew_clock_fanout
`default_nettype wire

//--- testbench/skew_fanout_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the register bus and the paired outputs of the fanout block.
module skew_fanout_monitor
  import skew_fanout_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PAIRS-1:0] pairOutputA,
  input wire logic [PAIRS-1:0] pairOutputB
);
  // High when the address names one of the three registers.
  logic hit;
  assign hit = (paddr == ADDR_SELECT) || (paddr == ADDR_CONTROL) ||
    (paddr == ADDR_STATUS);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  chk_ready_high: assert property (pready)
    else $error("pready was low.");
  chk_err_unmapped: assert property (psel && penable && !hit |-> pslverr)
    else $error("No error on an unmapped access.");
  chk_err_mapped: assert property (psel && penable && hit |-> !pslverr)
    else $error("Error on a mapped access.");
  chk_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("Error outside an access phase.");
  chk_zero_unmapped: assert property (psel && !penable && !pwrite && !hit
    ##1 psel && penable |-> prdata == 32'h00000000)
    else $error("Unmapped read returned data.");
  chk_read_stands: assert property (psel && penable && !pwrite |=>
    $stable(prdata))
    else $error("Read data moved after the access.");
  chk_pair_same: assert property (pairOutputA == pairOutputB)
    else $error("The two drivers of a pair differ.");
  chk_reset_quiet: assert property ($rose(nrst) |-> pairOutputA == 4'h0)
    else $error("Outputs not low after reset.");
endmodule // skew_fanout_monitor
bind programmable_skew_clock_fanout skew_fanout_monitor chk_u (
  .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pairOutputA(pairOutputA), .pairOutputB(pairOutputB)
);
`default_nettype wire

//--- testbench/clock_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// Board clock source and the trace that carries pair one back to the loop.
module clock_source_model (
  input wire logic clock,
  input wire logic run,
  input wire logic [6:0] period,
  input wire logic [3:0] fanout,
  output logic refClk,
  output logic loopReturn
);
  // Tick position inside one source period.
  logic [6:0] cnt_r = 7'h00;
  // The counter wraps after the programmed number of ticks.
  always_ff @(posedge clock) begin
    if (cnt_r >= period - 7'h01) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_r + 7'h01;
    end
  end
  // The source holds still until it is allowed to run.
  assign refClk = run && (cnt_r < (period >> 1));
  // A single buffer feeds back pair one at zero skew.
  assign loopReturn = fanout[0];
endmodule // clock_source_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the register bus and measures output edges against the source.
module testbench import skew_fanout_pkg::*; ;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, refClk, loopReturnInput;
  logic run = 1'b0;
  logic [6:0] period = 7'h28;
  logic [PAIRS-1:0] pairOutputA, pairOutputB;
  int n_fail = 0;
  int samples_checked = 0;
  int rise[4];
  int rises[4];
  int invMis, fallMis, k, nv;
  always #2 clock = ~clock;
  programmable_skew_clock_fanout dut_u (.clock(clock), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .refClk(refClk), .loopReturnInput(loopReturnInput),
    .pairOutputA(pairOutputA), .pairOutputB(pairOutputB));
  clock_source_model src_u (.clock(clock), .run(run), .period(period),
    .fanout(pairOutputA), .refClk(refClk), .loopReturn(loopReturnInput));
  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Ends the run as failed when a wait used up its bound.
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      n_fail++;
      finish_test();
    end
  endtask
  // Compares a register value.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Compares a measured count of ticks or edges.
  task automatic cmpn(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus transfer; read data and error land in rd and er.
  task automatic apb(input logic [11:0] a, input logic w,
      input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 64);
    guard(n, 64);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Select field of one pair from a code index, upper select first.
  function automatic logic [3:0] fld(input int i);
    return {2'(i / 3), 2'(i % 3)};
  endfunction
  // Ticks from a source rising edge to the first rise of each pair.
  task automatic measure();
    logic [3:0] last;
    logic lastRef;
    int n;
    lastRef = 1'b1;
    last = pairOutputA;
    n = 0;
    while (!(refClk === 1'b1 && lastRef === 1'b0) && n < 400) begin
      lastRef = refClk;
      last = pairOutputA;
      @(posedge clock);
      n++;
    end
    guard(n, 400);
    rise = '{-1, -1, -1, -1};
    for (n = 0; n < 60; n++) begin
      for (int p = 0; p < 4; p++) begin
        if (rise[p] < 0 && pairOutputA[p] === 1'b1 && last[p] === 1'b0)
          rise[p] = n;
      end
      last = pairOutputA;
      @(posedge clock);
    end
  endtask
  // Counts rises, inversion slips and lone falls of pair three.
  task automatic observe(input int n);
    logic [3:0] last;
    last = pairOutputA;
    rises = '{0, 0, 0, 0};
    invMis = 0;
    fallMis = 0;
    repeat (n) begin
      @(posedge clock);
      for (int p = 0; p < 4; p++) begin
        if (pairOutputA[p] === 1'b1 && last[p] === 1'b0) rises[p]++;
      end
      if (pairOutputA[3] !== ~pairOutputA[1]) invMis++;
      if (last[2] === 1'b1 && pairOutputA[2] === 1'b0 &&
          !(last[3] === 1'b1 && pairOutputA[3] === 1'b0)) fallMis++;
      last = pairOutputA;
    end
  endtask
  // Main sequence: reset, registers, bypass timing, then loop timing.
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    run <= 1'b1; // Source starts after power-up.
    apb(ADDR_SELECT, 1'b0, 32'h0);
    cmp(rd, {16'h0000, SELECT_RESET}); // Selects reset to middle.
    apb(ADDR_CONTROL, 1'b0, 32'h0);
    cmp(rd, {28'h0000000, CONTROL_RESET}); // Loop mode at reset.
    apb(12'hFFC, 1'b0, 32'h0);
    cmp({er, rd[30:0]}, 32'h80000000);
    apb(ADDR_STATUS, 1'b1, 32'hFFFFFFFF);
    cmp({31'h0, er}, 32'h0);
    for (int i = 0; i < 9; i++) begin
      apb(ADDR_CONTROL, 1'b1, (i % 2) ? 32'h9 : 32'h5); // Bypass.
      apb(ADDR_SELECT, 1'b1, {16'h0, fld(4), fld(i), 4'hF, fld(i)});
      measure();
      cmpn(rise[0] - rise[1], i - 4); // Pair one skew.
      if (i > 0 && i < 8) cmpn(rise[2] - rise[1], 2 * (i - 4));
      cmpn(rise[3] - rise[1], 0); // Own selects only.
    end
    apb(ADDR_STATUS, 1'b0, 32'h0);
    cmp({31'h0, rd[STAT_BYPASS_BIT]}, 32'h1); // Bypass flagged.
    apb(ADDR_SELECT, 1'b1, {16'h0, fld(8), fld(0), 4'hF, fld(4)});
    observe(160);
    observe(320);
    cmpn(invMis, 0); // Inverted output.
    cmpn(rises[2], 4); // Divide by two.
    cmpn(rises[0], 8); // Undivided rate.
    apb(ADDR_SELECT, 1'b1, {16'h0, fld(0), fld(8), 4'hF, fld(4)});
    observe(320);
    observe(320);
    cmpn(rises[2], 2); // Divide by four.
    cmpn(rises[3], 4); // Divide by two on pair four.
    cmpn(fallMis, 0); // Shared falling edges.
    apb(ADDR_SELECT, 1'b1, {16'h0, fld(2), fld(6), fld(7), fld(4)});
    for (int r = 0; r < 3; r++) begin
      nv = (r == 0) ? 44 : ((r == 1) ? 26 : 16);
      period <= 7'(nv);
      apb(ADDR_CONTROL, 1'b1, 32'(r)); // Range by output rate.
      k = 0;
      do begin
        apb(ADDR_STATUS, 1'b0, 32'h0);
        k++;
      end while (rd[STAT_LOCK_BIT] !== 1'b1 && k < 3000);
      guard(k, 3000);
      cmp({31'h0, rd[STAT_BYPASS_BIT]}, 32'h0); // Loop drives.
      cmpn((rd[STAT_ERR_LSB +: ERR_W] <= LOCK_TOL) ? 1 : 0, 1);
      measure();
      cmpn((rise[0] <= 1 || rise[0] >= nv - 1) ? 1 : 0, 1);
      cmpn((rise[1] - rise[0] + nv) % nv, 3); // Tick step.
      cmpn((rise[2] - rise[0] + nv) % nv, 4); // Even skew.
      cmpn((rise[3] - rise[0] + nv) % nv, nv - 4); // Early edge.
      observe(8 * nv);
      cmpn(rises[0], 8); // One rise per nominal period.
    end
    finish_test();
  end
endmodule // testbench
`default_nettype wire
